// ===== common/fep_cfg.svh
`ifndef FEP_CFG_SVH
`define FEP_CFG_SVH

// Register byte addresses on the AXI4-Lite slave.
`define FEP_A_CMD        8'h00
`define FEP_A_ADDR       8'h04
`define FEP_A_WDATA      8'h08
`define FEP_A_STATUS     8'h0C
`define FEP_A_CONFIG     8'h10
`define FEP_A_BANK       8'h14
`define FEP_A_IRQ_STAT   8'h18
`define FEP_A_IRQ_MASK   8'h1C
`define FEP_A_EFF_ADDR   8'h20

// Command opcodes.
`define FEP_OP_WRITE_REGS   8'h01
`define FEP_OP_PROGRAM      8'h02
`define FEP_OP_ERASE_4K     8'h20
`define FEP_OP_ERASE_SECTOR 8'hD8
`define FEP_OP_ERASE_BULK   8'h60
`define FEP_OP_OTP_PROGRAM  8'h42
`define FEP_OP_CLEAR_STATUS 8'h30
`define FEP_OP_LEGACY_LOW_POWER 8'hB9

// Status register fields.
`define FEP_SR_BUSY     0
`define FEP_SR_BP_LO    2
`define FEP_SR_BP_HI    4
`define FEP_SR_E_ERR    5
`define FEP_SR_P_ERR    6

// Configuration register one fields.
`define FEP_CR_FREEZE      0
`define FEP_CR_PARAM_LOC   2
`define FEP_CR_PROT_ORIGIN 5

// Interrupt status and mask fields.
`define FEP_IRQ_DONE    0
`define FEP_IRQ_P_ERR   1
`define FEP_IRQ_E_ERR   2
`define FEP_IRQ_REFUSED 3

// Reset values.
`define FEP_SR_RST      8'h00
`define FEP_CR_RST      8'h00
`define FEP_BANK_RST    8'h00

// Array geometry: 25 address bits, 128 KB of small parameter sectors.
`define FEP_ARRAY_LAST  25'h1FFFFFF
`define FEP_ARRAY_SIZE  26'h2000000
`define FEP_PROT_UNIT   26'h0010000

// Embedded operation time and its cycle count at 8 ns per cycle.
`define FEP_OP_TIME_NS  80
`define FEP_CLK_NS      8
`define FEP_OP_CYCLES   ((`FEP_OP_TIME_NS + `FEP_CLK_NS - 1) / `FEP_CLK_NS)

`endif

// ===== common/fep_pkg.sv
package fep_pkg;

  typedef enum logic [1:0] {
    FEP_IDLE = 2'b01,
    FEP_BUSY = 2'b10
  } fep_state_e;

  typedef enum logic [2:0] {
    FEP_K_PAGE  = 3'h0,
    FEP_K_4K    = 3'h1,
    FEP_K_64K   = 3'h2,
    FEP_K_256K  = 3'h3,
    FEP_K_BULK  = 3'h4,
    FEP_K_OTP   = 3'h5
  } fep_kind_e;

  typedef struct packed {
    fep_state_e  st;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [15:0] wdat;
    logic [7:0]  sr;
    logic [7:0]  cr;
    logic [7:0]  bank;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mk;
    logic [7:0]  cnt;
    logic [24:0] eff;
    fep_kind_e   kind;
    logic        commit;
    logic        fail_s1;
    logic        fail_s2;
    logic        strap_s1;
    logic        strap_s2;
    logic        uniform;
  } fep_state_s;

endpackage

// ===== verilog/fep_cmd.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fep_cfg.svh"

// Summary of operation
// - Internal failure sets program or erase error.
// - Program or erase on protected area errors.
// - Errored operation never commits to array.
// - Freeze bit blocks block-protection bit changes.
// - Freeze also locks location, origin, OTP.
// - No two-sector 8 KB erase command exists.
// - 4 KB erase only inside parameter sectors.
// - 64 KB erase, may cover sixteen small.
// - Uniform option turns sector erase 256 KB.
// - No deep power-down state exists.
// - Legacy low-power opcode writes bank register.
// - Bank bit 0 extends 24-bit command address.
module fep_cmd (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  input  wire logic        OP_FAIL_I,
  input  wire logic        UNIFORM_256K_I,
  output logic             IRQ_O,
  output logic             ARR_COMMIT_O,
  output logic [24:0]      ARR_ADDR_O,
  output fep_pkg::fep_kind_e ARR_KIND_O
);
  import fep_pkg::*;

  fep_state_s s_reg;
  fep_state_s s_next;

  function automatic logic [25:0] kind_size(fep_kind_e k);
    unique case (k)
      FEP_K_PAGE:  kind_size = 26'h0000100;
      FEP_K_4K:    kind_size = 26'h0001000;
      FEP_K_64K:   kind_size = 26'h0010000;
      FEP_K_256K:  kind_size = 26'h0040000;
      FEP_K_BULK:  kind_size = `FEP_ARRAY_SIZE;
      FEP_K_OTP:   kind_size = 26'h0000001;
      default:     kind_size = 26'h0000001;
    endcase
  endfunction

  // True when the address lies in the block-protected range.
  function automatic logic prot_hit(logic [24:0] a, logic [2:0] bp,
                                    logic from_bottom);
    logic [25:0] sz;
    logic [24:0] off;
    sz = '0;
    if (bp == 3'h7) begin
      sz = `FEP_ARRAY_SIZE;
    end else if (bp != 3'h0) begin
      sz = `FEP_PROT_UNIT << (bp - 3'h1);
    end
    off = from_bottom ? a : (`FEP_ARRAY_LAST - a);
    prot_hit = ({1'b0, off} < sz);
  endfunction

  function automatic logic [31:0] masked(logic [31:0] old_v,
                                         logic [31:0] new_v,
                                         logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    masked = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic mapped(logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `FEP_A_EFF_ADDR);
  endfunction

  logic        wr_go;
  logic        rd_go;
  logic        start;
  logic [24:0] eff_c;
  logic [24:0] base_c;
  logic [24:0] last_c;
  logic [25:0] size_c;
  logic        in_param;
  logic        is_erase;
  logic        refuse_c;
  logic        prot_c;
  fep_kind_e   kind_c;
  logic [3:0]  irq_set;
  logic [3:0]  irq_clr;
  logic [31:0] rd_val;
  logic [7:0]  new_cr;
  logic        fail_end;
  logic [31:0] wr_merged;

  always_comb begin
    s_next = s_reg;
    irq_set = '0;
    irq_clr = '0;
    wr_merged = '0;
    s_next.commit = 1'b0;
    s_next.fail_s1 = OP_FAIL_I;
    s_next.fail_s2 = s_reg.fail_s1;
    s_next.strap_s1 = UNIFORM_256K_I;
    s_next.strap_s2 = s_reg.strap_s1;

    // Write address and data are taken in either order.
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      s_next.w_got = 1'b1;
      s_next.wdata = S_AXI_WDATA_I;
      s_next.wstrb = S_AXI_WSTRB_I;
    end
    wr_go = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    start = 1'b0;
    if (wr_go) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? 2'b00 : 2'b10;
      unique case (s_reg.awaddr)
        `FEP_A_CMD: begin
          if (s_reg.wstrb[0]) begin
            if (s_reg.st == FEP_IDLE) begin
              start = 1'b1;
              s_next.opcode = s_reg.wdata[7:0];
            end else begin
              irq_set[`FEP_IRQ_REFUSED] = 1'b1;
            end
          end
        end
        `FEP_A_ADDR: begin
          wr_merged = masked({8'h00, s_reg.addr}, s_reg.wdata,
                             s_reg.wstrb);
          s_next.addr = wr_merged[23:0];
        end
        `FEP_A_WDATA: begin
          wr_merged = masked({16'h0000, s_reg.wdat}, s_reg.wdata,
                             s_reg.wstrb);
          s_next.wdat = wr_merged[15:0];
        end
        `FEP_A_IRQ_STAT: begin
          wr_merged = masked(32'h0, s_reg.wdata, s_reg.wstrb);
          irq_clr = wr_merged[3:0];
        end
        `FEP_A_IRQ_MASK: begin
          wr_merged = masked({28'h0, s_reg.irq_mk}, s_reg.wdata,
                             s_reg.wstrb);
          s_next.irq_mk = wr_merged[3:0];
        end
        default: begin
        end
      endcase
    end
    if (s_reg.bvalid && S_AXI_BREADY_I) begin
      s_next.bvalid = 1'b0;
    end

    unique case (S_AXI_ARADDR_I)
      `FEP_A_CMD:      rd_val = {24'h0, s_reg.opcode};
      `FEP_A_ADDR:     rd_val = {8'h00, s_reg.addr};
      `FEP_A_WDATA:    rd_val = {16'h0000, s_reg.wdat};
      `FEP_A_STATUS:   rd_val = {24'h0, s_reg.sr};
      `FEP_A_CONFIG:   rd_val = {24'h0, s_reg.cr};
      `FEP_A_BANK:     rd_val = {24'h0, s_reg.bank};
      `FEP_A_IRQ_STAT: rd_val = {28'h0, s_reg.irq_st};
      `FEP_A_IRQ_MASK: rd_val = {28'h0, s_reg.irq_mk};
      `FEP_A_EFF_ADDR: rd_val = {7'h00, s_reg.eff};
      default:         rd_val = 32'h0;
    endcase
    rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = mapped(S_AXI_ARADDR_I) ? 2'b00 : 2'b10;
    end else if (s_reg.rvalid && S_AXI_RREADY_I) begin
      s_next.rvalid = 1'b0;
    end

    // Command decode on the opcode being written.
    eff_c = {s_reg.bank[0], s_reg.addr};
    in_param = s_reg.cr[`FEP_CR_PARAM_LOC] ? (eff_c[24:17] == 8'hFF)
                                           : (eff_c[24:17] == 8'h00);
    kind_c = FEP_K_PAGE;
    is_erase = 1'b0;
    refuse_c = 1'b0;
    unique case (s_reg.wdata[7:0])
      `FEP_OP_PROGRAM: kind_c = FEP_K_PAGE;
      `FEP_OP_OTP_PROGRAM: kind_c = FEP_K_OTP;
      `FEP_OP_ERASE_4K: begin
        kind_c = FEP_K_4K;
        is_erase = 1'b1;
        refuse_c = s_reg.uniform || !in_param;
      end
      `FEP_OP_ERASE_SECTOR: begin
        kind_c = s_reg.uniform ? FEP_K_256K : FEP_K_64K;
        is_erase = 1'b1;
      end
      `FEP_OP_ERASE_BULK: begin
        kind_c = FEP_K_BULK;
        is_erase = 1'b1;
      end
      default: begin
      end
    endcase
    size_c = kind_size(kind_c);
    base_c = eff_c & ~(size_c[24:0] - 25'h1);
    last_c = base_c | (size_c[24:0] - 25'h1);
    prot_c = prot_hit(base_c, s_reg.sr[`FEP_SR_BP_HI:`FEP_SR_BP_LO],
                      s_reg.cr[`FEP_CR_PROT_ORIGIN])
           || prot_hit(last_c, s_reg.sr[`FEP_SR_BP_HI:`FEP_SR_BP_LO],
                       s_reg.cr[`FEP_CR_PROT_ORIGIN]);
    if (kind_c == FEP_K_OTP) begin
      prot_c = s_reg.cr[`FEP_CR_FREEZE];
    end

    new_cr = s_reg.wdat[15:8];
    if (s_reg.cr[`FEP_CR_FREEZE]) begin
      new_cr[`FEP_CR_PARAM_LOC] = s_reg.cr[`FEP_CR_PARAM_LOC];
      new_cr[`FEP_CR_PROT_ORIGIN] = s_reg.cr[`FEP_CR_PROT_ORIGIN];
      new_cr[`FEP_CR_FREEZE] = 1'b1;
    end

    if (start) begin
      unique case (s_reg.wdata[7:0])
        `FEP_OP_WRITE_REGS: begin
          if (!s_reg.cr[`FEP_CR_FREEZE]) begin
            s_next.sr[`FEP_SR_BP_HI:`FEP_SR_BP_LO] =
              s_reg.wdat[`FEP_SR_BP_HI:`FEP_SR_BP_LO];
          end
          s_next.cr = new_cr;
          irq_set[`FEP_IRQ_DONE] = 1'b1;
        end
        `FEP_OP_CLEAR_STATUS: begin
          s_next.sr[`FEP_SR_E_ERR] = 1'b0;
          s_next.sr[`FEP_SR_P_ERR] = 1'b0;
          irq_set[`FEP_IRQ_DONE] = 1'b1;
        end
        `FEP_OP_LEGACY_LOW_POWER: begin
          s_next.bank = s_reg.wdat[7:0];
          irq_set[`FEP_IRQ_DONE] = 1'b1;
        end
        `FEP_OP_PROGRAM, `FEP_OP_OTP_PROGRAM, `FEP_OP_ERASE_4K,
        `FEP_OP_ERASE_SECTOR, `FEP_OP_ERASE_BULK: begin
          if (refuse_c) begin
            irq_set[`FEP_IRQ_REFUSED] = 1'b1;
          end else if (prot_c) begin
            if (is_erase) begin
              s_next.sr[`FEP_SR_E_ERR] = 1'b1;
              irq_set[`FEP_IRQ_E_ERR] = 1'b1;
            end else begin
              s_next.sr[`FEP_SR_P_ERR] = 1'b1;
              irq_set[`FEP_IRQ_P_ERR] = 1'b1;
            end
            irq_set[`FEP_IRQ_DONE] = 1'b1;
          end else begin
            s_next.st = FEP_BUSY;
            s_next.sr[`FEP_SR_BUSY] = 1'b1;
            s_next.cnt = 8'(`FEP_OP_CYCLES - 1);
            s_next.eff = base_c;
            s_next.kind = kind_c;
          end
        end
        default: begin
          // Unknown opcodes, an 8 KB erase among them, are refused.
          irq_set[`FEP_IRQ_REFUSED] = 1'b1;
        end
      endcase
    end

    fail_end = 1'b0;
    if (s_reg.st == FEP_BUSY) begin
      if (s_reg.cnt != 8'h00) begin
        s_next.cnt = s_reg.cnt - 8'h01;
      end else begin
        s_next.st = FEP_IDLE;
        s_next.sr[`FEP_SR_BUSY] = 1'b0;
        irq_set[`FEP_IRQ_DONE] = 1'b1;
        fail_end = s_reg.fail_s2;
        if (fail_end) begin
          if (s_reg.kind inside {FEP_K_PAGE, FEP_K_OTP}) begin
            s_next.sr[`FEP_SR_P_ERR] = 1'b1;
            irq_set[`FEP_IRQ_P_ERR] = 1'b1;
          end else begin
            s_next.sr[`FEP_SR_E_ERR] = 1'b1;
            irq_set[`FEP_IRQ_E_ERR] = 1'b1;
          end
        end else begin
          s_next.commit = 1'b1;
        end
      end
    end

    // A new event wins over a clear in the same cycle.
    s_next.irq_st = (s_reg.irq_st & ~irq_clr) | irq_set;

    if (RST_I) begin
      s_next = '0;
      s_next.st = FEP_IDLE;
      s_next.kind = FEP_K_PAGE;
      s_next.sr = `FEP_SR_RST;
      s_next.cr = `FEP_CR_RST;
      s_next.bank = `FEP_BANK_RST;
      s_next.strap_s1 = UNIFORM_256K_I;
      s_next.strap_s2 = s_reg.strap_s1;
      s_next.uniform = s_reg.strap_s2;
    end
  end

  always_ff @(posedge MCLK_I) begin
    s_reg <= s_next;
  end

  assign S_AXI_AWREADY_O = !s_reg.aw_got && !s_reg.bvalid;
  assign S_AXI_WREADY_O  = !s_reg.w_got && !s_reg.bvalid;
  assign S_AXI_BVALID_O  = s_reg.bvalid;
  assign S_AXI_BRESP_O   = s_reg.bresp;
  assign S_AXI_ARREADY_O = !s_reg.rvalid;
  assign S_AXI_RVALID_O  = s_reg.rvalid;
  assign S_AXI_RDATA_O   = s_reg.rdata;
  assign S_AXI_RRESP_O   = s_reg.rresp;
  assign IRQ_O           = |(s_reg.irq_st & s_reg.irq_mk);
  assign ARR_COMMIT_O    = s_reg.commit;
  assign ARR_ADDR_O      = s_reg.eff;
  assign ARR_KIND_O      = s_reg.kind;

  logic busy_end;
  assign busy_end = (s_reg.st == FEP_BUSY) && (s_reg.cnt == 8'h00);

  sequence op_ends_failed;
    busy_end && s_reg.fail_s2;
  endsequence

  a_fail_sets_err: assert property (@(posedge MCLK_I) disable iff (RST_I)
    op_ends_failed |=> (s_reg.sr[`FEP_SR_P_ERR] || s_reg.sr[`FEP_SR_E_ERR])
  ) else $error("Failed operation left no error bit.");

  a_prot_no_run: assert property (@(posedge MCLK_I) disable iff (RST_I)
    start && prot_c && !refuse_c && (kind_c != FEP_K_OTP)
    && (s_reg.wdata[7:0] inside {`FEP_OP_PROGRAM, `FEP_OP_ERASE_4K,
        `FEP_OP_ERASE_SECTOR, `FEP_OP_ERASE_BULK})
    |=> s_reg.st == FEP_IDLE && (s_reg.sr[`FEP_SR_P_ERR]
        || s_reg.sr[`FEP_SR_E_ERR])
  ) else $error("Protected target did not raise an error.");

  a_err_no_commit: assert property (@(posedge MCLK_I) disable iff (RST_I)
    op_ends_failed |=> !ARR_COMMIT_O
  ) else $error("Array commit after a failed operation.");

  a_freeze_bp: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_reg.cr[`FEP_CR_FREEZE] |=> $stable(s_reg.sr[4:2])
  ) else $error("Protection bits changed while frozen.");

  a_freeze_cfg: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_reg.cr[`FEP_CR_FREEZE] |=> $stable(s_reg.cr[`FEP_CR_PARAM_LOC])
      && $stable(s_reg.cr[`FEP_CR_PROT_ORIGIN]) && s_reg.cr[0]
  ) else $error("Frozen configuration bits changed.");

  a_small_erase: assert property (@(posedge MCLK_I) disable iff (RST_I)
    start && (s_reg.wdata[7:0] == `FEP_OP_ERASE_4K) && !in_param
    |=> s_reg.st == FEP_IDLE && s_reg.irq_st[`FEP_IRQ_REFUSED]
  ) else $error("Small erase accepted outside parameter area.");

  a_sector_size: assert property (@(posedge MCLK_I) disable iff (RST_I)
    start && (s_reg.wdata[7:0] == `FEP_OP_ERASE_SECTOR) && !prot_c
    |=> ARR_KIND_O == ($past(s_reg.uniform) ? FEP_K_256K : FEP_K_64K)
  ) else $error("Sector erase size wrong for option.");

  a_bank_write: assert property (@(posedge MCLK_I) disable iff (RST_I)
    start && (s_reg.wdata[7:0] == `FEP_OP_LEGACY_LOW_POWER)
    |=> s_reg.bank == $past(s_reg.wdat[7:0]) && s_reg.st == FEP_IDLE
  ) else $error("Legacy opcode did not load bank.");

  a_err_sticky: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_reg.sr[`FEP_SR_E_ERR] && !(start
      && s_reg.wdata[7:0] == `FEP_OP_CLEAR_STATUS)
    |=> s_reg.sr[`FEP_SR_E_ERR]
  ) else $error("Erase error cleared without request.");

  a_commit_time: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $rose(s_reg.st == FEP_BUSY) |-> ##[1:40] (s_reg.st == FEP_IDLE)
  ) else $error("Embedded operation ran too long.");

endmodule

// ===== tb/fep_arr_model.sv
`timescale 1ns/1ps
module fep_arr_model (
  input  wire logic               clk_i,
  input  wire logic               commit_i,
  input  wire logic [24:0]        addr_i,
  input  wire fep_pkg::fep_kind_e kind_i,
  input  wire logic               fail_req_i,
  output logic                    op_fail_o,
  output int                      commits_o,
  output logic [24:0]             last_addr_o,
  output fep_pkg::fep_kind_e      last_kind_o
);
  import fep_pkg::*;

  // The embedded operation fails for as long as the bench asks for it.
  assign op_fail_o = fail_req_i;

  initial commits_o = 0;

  // Every committed change of the array is counted and remembered.
  always @(posedge clk_i) begin
    if (commit_i === 1'b1) begin
      commits_o   <= commits_o + 1;
      last_addr_o <= addr_i;
      last_kind_o <= kind_i;
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "fep_cfg.svh"
module tb;
  import fep_pkg::*;
  logic        clk;
  logic        rst      = 1'b1;
  logic        awvalid  = 1'b0;
  logic        awready;
  logic [7:0]  awaddr   = 8'h00;
  logic        wvalid   = 1'b0;
  logic        wready;
  logic [31:0] wdata    = 32'h0;
  logic        bvalid;
  logic        bready   = 1'b0;
  logic [1:0]  bresp;
  logic        arvalid  = 1'b0;
  logic        arready;
  logic [7:0]  araddr   = 8'h00;
  logic        rvalid;
  logic        rready   = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        fail_req = 1'b0;
  logic        op_fail;
  logic        uniform  = 1'b0;
  logic        irq;
  logic        commit;
  logic [24:0] arr_addr;
  fep_kind_e   arr_kind;
  int          commits;
  logic [24:0] last_addr;
  fep_kind_e   last_kind;
  logic [1:0]  r;
  int          failures = 0;
  int          total_checks = 0;

  fep_cmd i_dut (
    .MCLK_I(clk), .RST_I(rst),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .OP_FAIL_I(op_fail),
    .UNIFORM_256K_I(uniform), .IRQ_O(irq), .ARR_COMMIT_O(commit),
    .ARR_ADDR_O(arr_addr), .ARR_KIND_O(arr_kind)
  );

  fep_arr_model i_arr (
    .clk_i(clk), .commit_i(commit), .addr_i(arr_addr),
    .kind_i(arr_kind), .fail_req_i(fail_req), .op_fail_o(op_fail),
    .commits_o(commits), .last_addr_o(last_addr),
    .last_kind_o(last_kind)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tmo();
    failures++;
    end_of_test();
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      if (n > 100) tmo();
    end
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      if (n > 100) tmo();
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, r);
    chk(n, d, e);
  endtask

  task automatic start(input logic [7:0] op, input logic [23:0] ad,
                       input logic [15:0] wd);
    wr(`FEP_A_ADDR, {8'h00, ad}, r);
    wr(`FEP_A_WDATA, {16'h0000, wd}, r);
    wr(`FEP_A_CMD, {24'h000000, op}, r);
  endtask

  task automatic idle();
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0) begin
      rd(`FEP_A_STATUS, d, r);
      n++;
      if (n > 50) tmo();
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] ad,
                     input logic [15:0] wd);
    start(op, ad, wd);
    idle();
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk("irq", irq, 1'b0);
    chk("kind", arr_kind, FEP_K_PAGE);
    rchk("status", `FEP_A_STATUS, 32'h0);
    rchk("config", `FEP_A_CONFIG, 32'h0);
    rchk("bank", `FEP_A_BANK, 32'h0);
    rchk("mask", `FEP_A_IRQ_MASK, 32'h0);
    rd(8'h24, d, r);
    chk("rresp", r, 2'b10);
    wr(8'h24, 32'h1, r);
    chk("bresp", r, 2'b10);
    wr(8'h02, 32'h1, r);
    chk("bresp", r, 2'b10);
  endtask

  task automatic t_erase();
    int c0;
    c0 = commits;
    cmd(`FEP_OP_ERASE_SECTOR, 24'h123456, 16'h0);
    chk("commits", commits, c0 + 1);
    chk("kind", last_kind, FEP_K_64K);
    chk("addr", last_addr, 25'h0120000);
    fail_req <= 1'b1;
    cmd(`FEP_OP_ERASE_SECTOR, 24'h123456, 16'h0);
    chk("commits", commits, c0 + 1);
    rchk("status", `FEP_A_STATUS, 32'h20);
    fail_req <= 1'b0;
    cmd(`FEP_OP_PROGRAM, 24'h000100, 16'h0);
    chk("commits", commits, c0 + 2);
    rchk("status", `FEP_A_STATUS, 32'h20);
    fail_req <= 1'b1;
    cmd(`FEP_OP_PROGRAM, 24'h000100, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h60);
    fail_req <= 1'b0;
    cmd(`FEP_OP_CLEAR_STATUS, 24'h0, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h0);
  endtask

  task automatic t_prot();
    int c0;
    c0 = commits;
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h001C);
    cmd(`FEP_OP_PROGRAM, 24'h0, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h5C);
    cmd(`FEP_OP_ERASE_SECTOR, 24'h0, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h7C);
    chk("commits", commits, c0);
    cmd(`FEP_OP_CLEAR_STATUS, 24'h0, 16'h0);
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h0004);
    cmd(`FEP_OP_LEGACY_LOW_POWER, 24'h0, 16'h0001);
    cmd(`FEP_OP_ERASE_SECTOR, 24'hFF0000, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h24);
    cmd(`FEP_OP_ERASE_SECTOR, 24'hFEFFFF, 16'h0);
    chk("commits", commits, c0 + 1);
    chk("addr", last_addr, 25'h1FE0000);
    cmd(`FEP_OP_CLEAR_STATUS, 24'h0, 16'h0);
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h0000);
    cmd(`FEP_OP_LEGACY_LOW_POWER, 24'h0, 16'h0000);
  endtask

  task automatic t_param();
    int c0;
    c0 = commits;
    wr(`FEP_A_IRQ_STAT, 32'hF, r);
    cmd(`FEP_OP_ERASE_4K, 24'h01F000, 16'h0);
    chk("kind", last_kind, FEP_K_4K);
    chk("addr", last_addr, 25'h001F000);
    cmd(`FEP_OP_ERASE_4K, 24'h020000, 16'h0);
    chk("commits", commits, c0 + 1);
    rchk("irq_stat", `FEP_A_IRQ_STAT, 32'h9);
    wr(`FEP_A_IRQ_STAT, 32'hF, r);
    cmd(8'h52, 24'h0, 16'h0);
    chk("commits", commits, c0 + 1);
    rchk("irq_stat", `FEP_A_IRQ_STAT, 32'h8);
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h0400);
    cmd(`FEP_OP_LEGACY_LOW_POWER, 24'h0, 16'h0001);
    rchk("bank", `FEP_A_BANK, 32'h1);
    rchk("status", `FEP_A_STATUS, 32'h0);
    cmd(`FEP_OP_ERASE_4K, 24'hFE0000, 16'h0);
    chk("addr", last_addr, 25'h1FE0000);
    rchk("eff", `FEP_A_EFF_ADDR, 32'h1FE0000);
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h0000);
    cmd(`FEP_OP_LEGACY_LOW_POWER, 24'h0, 16'h0000);
  endtask

  task automatic t_irq();
    int c0;
    c0 = commits;
    wr(`FEP_A_IRQ_STAT, 32'hF, r);
    start(`FEP_OP_ERASE_SECTOR, 24'h0, 16'h0);
    wr(`FEP_A_CMD, {24'h0, `FEP_OP_PROGRAM}, r);
    idle();
    chk("commits", commits, c0 + 1);
    rchk("irq_stat", `FEP_A_IRQ_STAT, 32'h9);
    chk("irq", irq, 1'b0);
    wr(`FEP_A_IRQ_MASK, 32'h8, r);
    @(posedge clk);
    chk("irq", irq, 1'b1);
    wr(`FEP_A_IRQ_STAT, 32'h8, r);
    @(posedge clk);
    chk("irq", irq, 1'b0);
    rchk("irq_stat", `FEP_A_IRQ_STAT, 32'h1);
  endtask

  task automatic t_freeze();
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h250C);
    rchk("config", `FEP_A_CONFIG, 32'h25);
    cmd(`FEP_OP_WRITE_REGS, 24'h0, 16'h0000);
    rchk("config", `FEP_A_CONFIG, 32'h25);
    rchk("status", `FEP_A_STATUS, 32'h0C);
    cmd(`FEP_OP_OTP_PROGRAM, 24'h0, 16'h0);
    rchk("status", `FEP_A_STATUS, 32'h4C);
  endtask

  task automatic t_uniform();
    int c0;
    uniform <= 1'b1;
    do_reset();
    c0 = commits;
    rchk("config", `FEP_A_CONFIG, 32'h0);
    cmd(`FEP_OP_ERASE_SECTOR, 24'h050000, 16'h0);
    chk("kind", last_kind, FEP_K_256K);
    chk("addr", last_addr, 25'h0040000);
    cmd(`FEP_OP_ERASE_4K, 24'h001000, 16'h0);
    chk("commits", commits, c0 + 1);
    rchk("irq_stat", `FEP_A_IRQ_STAT, 32'h9);
  endtask

  initial begin
    do_reset();
    t_reset();
    t_erase();
    t_prot();
    t_param();
    t_irq();
    t_freeze();
    t_uniform();
    end_of_test();
  end
endmodule
